//--- rtl/branch_io_ctl_instr_exec.sv
module branch_io_ctl_instr_exec #(
  parameter int PC_W = 11,
  parameter int NUM_PORTS = 16
) (
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  input wire logic [7:0] ROM_DATA_IN,
  input wire logic CARRY_FLAG_IN,
  input wire logic ZERO_FLAG_IN,
  input wire logic [15:0] GEN_FLAGS_IN,
  input wire logic [3:0] ACCUM_IN,
  input wire logic [3:0] EXT_REG_IN,
  input wire logic [3:0] DATA_POINTER_LOW_IN,
  input wire logic [NUM_PORTS*4-1:0] PORT_PINS_IN,
  output logic [PC_W-1:0] PC_OUT,
  output logic [NUM_PORTS*4-1:0] PORT_PINS_OUT,
  output logic ACC_WR_OUT,
  output logic [3:0] ACC_DATA_OUT,
  output logic ZF_WR_OUT,
  output logic ZF_DATA_OUT,
  output logic EXT_WR_OUT,
  output logic [3:0] EXT_DATA_OUT,
  output logic [3:0] CONTROL_BITS_OUT,
  output logic TIMER_LOAD_OUT,
  output logic [7:0] TIMER_COUNT_OUT,
  output logic TIMER_OVF_CLR_OUT
);

  // Sequencer state and program counter
  branch_io_ctl_pkg::exec_state_t state_r, state_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt;
  logic [7:0] first_byte_r, first_byte_nxt; // First byte kept for cycle two

  // Port output latches, one nibble per port
  logic [NUM_PORTS*4-1:0] latch_r, latch_nxt;

  // Pin synchroniser; only the second stage reads the first
  logic [NUM_PORTS*4-1:0] sync1_r, sync2_r, sync3_r;
  logic [NUM_PORTS*4-1:0] pins_r, pins_nxt; // Agreed pin level

  // Control register
  logic [3:0] ctl_r, ctl_nxt;

  // Registered strobes and data toward the core and timer
  logic acc_wr_r, acc_wr_nxt;
  logic [3:0] acc_data_r, acc_data_nxt;
  logic zf_wr_r, zf_wr_nxt;
  logic zf_data_r, zf_data_nxt;
  logic ext_wr_r, ext_wr_nxt;
  logic [3:0] ext_data_r, ext_data_nxt;
  logic tm_load_r, tm_load_nxt;
  logic [7:0] tm_data_r, tm_data_nxt;
  logic tm_clr_r, tm_clr_nxt;

  // Decode helpers
  logic [3:0] hi1, lo1, hi2, lo2;
  logic [PC_W-1:0] pc_inc;
  logic [PC_W-1:0] pc_branch;
  logic br_taken;
  logic [3:0] port_nibble;
  logic [3:0] latch_nibble;
  logic [3:0] bit_mask;
  logic [3:0] new_nibble;
  logic [3:0] new_ctl;
  int sel;

  // Pin synchroniser next values; a change counts once stages two and three agree
  always_comb begin
    pins_nxt = pins_r;
    if (sync2_r == sync3_r) begin
      pins_nxt = sync3_r;
    end
  end

  // Decode and execute
  always_comb begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    first_byte_nxt = first_byte_r;
    latch_nxt = latch_r;
    ctl_nxt = ctl_r;
    acc_wr_nxt = 1'b0;
    acc_data_nxt = acc_data_r;
    zf_wr_nxt = 1'b0;
    zf_data_nxt = zf_data_r;
    ext_wr_nxt = 1'b0;
    ext_data_nxt = ext_data_r;
    tm_load_nxt = 1'b0;
    tm_data_nxt = tm_data_r;
    tm_clr_nxt = 1'b0;
    br_taken = 1'b0;
    hi1 = first_byte_r[7:4];
    lo1 = first_byte_r[3:0];
    hi2 = ROM_DATA_IN[7:4];
    lo2 = ROM_DATA_IN[3:0];
    pc_inc = pc_r + PC_W'(1);
    // Only the low byte changes, so the target stays in the page
    pc_branch = {pc_r[PC_W-1:8], lo1, lo2}; // RULE4
    sel = 4 * int'(DATA_POINTER_LOW_IN);
    port_nibble = pins_r[sel +: 4];
    latch_nibble = latch_r[sel +: 4];
    bit_mask = 4'h1 << first_byte_r[1:0];
    new_nibble = latch_nibble;
    new_ctl = ctl_r;
    unique case (state_r)
      branch_io_ctl_pkg::ST_FETCH: begin
        // The byte at the program counter is examined this cycle
        first_byte_nxt = ROM_DATA_IN;
        pc_nxt = pc_inc;
        if (ROM_DATA_IN[7:4] == branch_io_ctl_pkg::HI_BR_CLEAR ||
            ROM_DATA_IN[7:4] == branch_io_ctl_pkg::HI_BR_SET ||
            ROM_DATA_IN[7:4] == branch_io_ctl_pkg::HI_FLAG_SET ||
            ROM_DATA_IN[7:4] == branch_io_ctl_pkg::HI_FLAG_CLEAR ||
            ROM_DATA_IN == branch_io_ctl_pkg::OP_CTL_SET ||
            ROM_DATA_IN == branch_io_ctl_pkg::OP_CTL_CLEAR) begin
          // Two-byte forms take a second cycle for the operand
          state_nxt = branch_io_ctl_pkg::ST_SECOND; // RULE1 RULE11
        end else if (ROM_DATA_IN[3:2] == branch_io_ctl_pkg::PORT_BIT_TAG &&
                     (ROM_DATA_IN[7:4] == branch_io_ctl_pkg::HI_PORT_BIT_SET ||
                      ROM_DATA_IN[7:4] == branch_io_ctl_pkg::HI_PORT_BIT_CLEAR)) begin
          // Port bit forms are one byte but need a modify cycle
          state_nxt = branch_io_ctl_pkg::ST_MODIFY; // RULE9
        end else if (ROM_DATA_IN == branch_io_ctl_pkg::OP_PORT_TO_ACCUM) begin
          // Accumulator takes the agreed pin level of the addressed port
          acc_wr_nxt = 1'b1; // RULE7
          acc_data_nxt = port_nibble;
          zf_wr_nxt = 1'b1;
          zf_data_nxt = (port_nibble == branch_io_ctl_pkg::NIBBLE_ZERO);
        end else if (ROM_DATA_IN == branch_io_ctl_pkg::OP_ACCUM_TO_PORT) begin
          // Latch of the addressed port takes the accumulator
          latch_nxt[sel +: 4] = ACCUM_IN; // RULE8
        end else if (ROM_DATA_IN == branch_io_ctl_pkg::OP_TIMER_LOAD) begin
          // Timer gets extension over accumulator, overflow flag cleared
          tm_load_nxt = 1'b1; // RULE13
          tm_data_nxt = {EXT_REG_IN, ACCUM_IN};
          tm_clr_nxt = 1'b1;
        end else begin
          // Anything else belongs to other groups and is stepped over
          state_nxt = branch_io_ctl_pkg::ST_FETCH;
        end
      end
      branch_io_ctl_pkg::ST_SECOND: begin
        state_nxt = branch_io_ctl_pkg::ST_FETCH;
        // Untaken or unrelated second bytes simply fall through
        pc_nxt = pc_inc; // RULE15
        if (hi1 == branch_io_ctl_pkg::HI_BR_CLEAR) begin
          if (hi2 == branch_io_ctl_pkg::SEL_CARRY) begin
            br_taken = !CARRY_FLAG_IN; // RULE1
          end else if (hi2 == branch_io_ctl_pkg::SEL_ZERO) begin
            br_taken = !ZERO_FLAG_IN; // RULE3
          end
        end else if (hi1 == branch_io_ctl_pkg::HI_BR_SET) begin
          if (hi2 == branch_io_ctl_pkg::SEL_CARRY) begin
            br_taken = CARRY_FLAG_IN; // RULE14
          end else if (hi2 == branch_io_ctl_pkg::SEL_ZERO) begin
            br_taken = ZERO_FLAG_IN; // RULE2
          end
        end else if (hi1 == branch_io_ctl_pkg::HI_FLAG_SET) begin
          // Second-byte high nibble names the general flag
          br_taken = GEN_FLAGS_IN[hi2]; // RULE5
        end else if (hi1 == branch_io_ctl_pkg::HI_FLAG_CLEAR) begin
          br_taken = !GEN_FLAGS_IN[hi2]; // RULE6
        end else if (hi2 == branch_io_ctl_pkg::SEL_CTL) begin
          if (first_byte_r == branch_io_ctl_pkg::OP_CTL_SET) begin
            ctl_nxt = ctl_r | lo2; // RULE11
          end else begin
            new_ctl = ctl_r & ~lo2; // RULE12
            ctl_nxt = new_ctl;
            zf_wr_nxt = 1'b1;
            zf_data_nxt = (new_ctl == branch_io_ctl_pkg::NIBBLE_ZERO);
          end
        end
        if (br_taken) begin
          pc_nxt = pc_branch; // RULE4
        end
      end
      branch_io_ctl_pkg::ST_MODIFY: begin
        // Read-modify-write of the output latch, never of the pins
        state_nxt = branch_io_ctl_pkg::ST_FETCH;
        if (hi1 == branch_io_ctl_pkg::HI_PORT_BIT_SET) begin
          new_nibble = latch_nibble | bit_mask; // RULE9
        end else begin
          new_nibble = latch_nibble & ~bit_mask; // RULE10
          zf_wr_nxt = 1'b1;
          zf_data_nxt = (new_nibble == branch_io_ctl_pkg::NIBBLE_ZERO);
          // Extension register is overwritten with the old latch value
          ext_wr_nxt = 1'b1; // RULE10
          ext_data_nxt = latch_nibble;
        end
        latch_nxt[sel +: 4] = new_nibble;
      end
      default: begin
        state_nxt = branch_io_ctl_pkg::ST_FETCH;
      end
    endcase
  end

  // Sequencer registers; all state freezes while the clock enable is low
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      // Start from the first program byte
      state_r <= branch_io_ctl_pkg::ST_FETCH;
      pc_r <= '0;
      first_byte_r <= 8'h00;
    end else if (CE_IN) begin
      // Step only on enabled cycles
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      first_byte_r <= first_byte_nxt;
    end
  end

  // Port output latches
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      // All latches low, so no pin is driven high before software asks
      latch_r <= '0;
    end else if (CE_IN) begin
      latch_r <= latch_nxt;
    end
  end

  // Pin synchroniser chain and agreed level
  // The chain also freezes with the enable, so a pin read lags by
  // four enabled cycles; a trade of latency for a clean sample
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      // Cleared stages read as all ports low until pins settle
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      pins_r <= '0;
    end else if (CE_IN) begin
      // First stage may go metastable; only the second stage reads it
      sync1_r <= PORT_PINS_IN;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      pins_r <= pins_nxt;
    end
  end

  // Control register
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      ctl_r <= branch_io_ctl_pkg::CTL_RESET;
    end else if (CE_IN) begin
      // Changes only on the second cycle of a mask instruction
      ctl_r <= ctl_nxt;
    end
  end

  // Strobes and data toward the core and the timer
  // A strobe stays up while the enable is low, so a frozen core
  // still sees it on its next enabled edge
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      // No write is requested during reset
      acc_wr_r <= 1'b0;
      acc_data_r <= 4'h0;
      zf_wr_r <= 1'b0;
      zf_data_r <= 1'b0;
      ext_wr_r <= 1'b0;
      ext_data_r <= 4'h0;
      tm_load_r <= 1'b0;
      tm_data_r <= 8'h00;
      tm_clr_r <= 1'b0;
    end else if (CE_IN) begin
      // Pulses last one enabled cycle; data holds until the next write
      acc_wr_r <= acc_wr_nxt;
      acc_data_r <= acc_data_nxt;
      zf_wr_r <= zf_wr_nxt;
      zf_data_r <= zf_data_nxt;
      ext_wr_r <= ext_wr_nxt;
      ext_data_r <= ext_data_nxt;
      tm_load_r <= tm_load_nxt;
      tm_data_r <= tm_data_nxt;
      tm_clr_r <= tm_clr_nxt;
    end
  end

  // Outputs straight from the registers
  assign PC_OUT = pc_r;
  assign PORT_PINS_OUT = latch_r;
  assign ACC_WR_OUT = acc_wr_r;
  assign ACC_DATA_OUT = acc_data_r;
  assign ZF_WR_OUT = zf_wr_r;
  assign ZF_DATA_OUT = zf_data_r;
  assign EXT_WR_OUT = ext_wr_r;
  assign EXT_DATA_OUT = ext_data_r;
  assign CONTROL_BITS_OUT = ctl_r;
  assign TIMER_LOAD_OUT = tm_load_r;
  assign TIMER_COUNT_OUT = tm_data_r;
  assign TIMER_OVF_CLR_OUT = tm_clr_r;

endmodule : branch_io_ctl_instr_exec

//--- rtl/branch_io_ctl_pkg.sv
// Overview of operation
// RULE1: Carry-clear branch, two bytes, two cycles
// RULE2: Zero-set branch jumps when zero flag one
// RULE3: Zero-clear branch jumps when zero flag zero
// RULE4: Taken branch replaces only low eight bits
// RULE5: Flag-set branch tests one of sixteen flags
// RULE6: Flag-clear branch jumps when chosen flag zero
// RULE7: Port input loads accumulator, updates zero flag
// RULE8: Port output drives accumulator onto addressed port
// RULE9: Port bit set, one byte, two cycles
// RULE10: Port bit clear, zero flag, extension destroyed
// RULE11: Control bits set by OR of mask
// RULE12: Control bits cleared by mask, zero flag
// RULE13: Timer load from extension and accumulator
// RULE14: Carry-set branch jumps when carry flag one
// RULE15: Untaken branch falls through after two cycles
package branch_io_ctl_pkg;

  // First-byte high nibbles of the two-byte branches
  localparam logic [3:0] HI_BR_CLEAR = 4'h3;
  localparam logic [3:0] HI_BR_SET = 4'h7;
  localparam logic [3:0] HI_FLAG_SET = 4'hd;
  localparam logic [3:0] HI_FLAG_CLEAR = 4'h9;

  // Second-byte high nibbles selecting carry or zero test
  localparam logic [3:0] SEL_CARRY = 4'hf;
  localparam logic [3:0] SEL_ZERO = 4'he;

  // Single-byte opcodes
  localparam logic [7:0] OP_PORT_TO_ACCUM = 8'h0c;
  localparam logic [7:0] OP_ACCUM_TO_PORT = 8'h61;
  localparam logic [7:0] OP_TIMER_LOAD = 8'hf9;

  // Port bit instructions: high nibble plus 01 in bits 3:2
  localparam logic [3:0] HI_PORT_BIT_SET = 4'h0;
  localparam logic [3:0] HI_PORT_BIT_CLEAR = 4'h2;
  localparam logic [1:0] PORT_BIT_TAG = 2'h1;

  // Control bit instructions: first byte, second-byte high nibble
  localparam logic [7:0] OP_CTL_SET = 8'h28;
  localparam logic [7:0] OP_CTL_CLEAR = 8'h29;
  localparam logic [3:0] SEL_CTL = 4'hc;

  // Control reset value and zero-nibble compare constant
  localparam logic [3:0] CTL_RESET = 4'h0;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;

  // Execution sequence of one instruction
  typedef enum logic [1:0] {
    ST_FETCH,
    ST_SECOND,
    ST_MODIFY
  } exec_state_t;

endpackage : branch_io_ctl_pkg

//--- sim/branch_io_ctl_monitor.sv
module branch_io_ctl_monitor #(
  parameter int PC_W = 11,
  parameter int NUM_PORTS = 16
) (
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  input wire logic [7:0] ROM_DATA_IN,
  input wire logic [3:0] ACCUM_IN,
  input wire logic [3:0] EXT_REG_IN,
  input wire logic [3:0] DATA_POINTER_LOW_IN,
  input wire logic [PC_W-1:0] PC_OUT,
  input wire logic [NUM_PORTS*4-1:0] PORT_PINS_OUT,
  input wire logic ACC_WR_OUT,
  input wire logic [3:0] ACC_DATA_OUT,
  input wire logic ZF_WR_OUT,
  input wire logic ZF_DATA_OUT,
  input wire logic [3:0] CONTROL_BITS_OUT,
  input wire logic TIMER_LOAD_OUT,
  input wire logic [7:0] TIMER_COUNT_OUT,
  input wire logic TIMER_OVF_CLR_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  // One domain, so clock and reset are given once
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);
  AST_TMR_PAIR: assert property (TIMER_LOAD_OUT == TIMER_OVF_CLR_OUT)
    else $error("timer load and overflow clear differ");
  AST_TMR_DATA: assert property (TIMER_LOAD_OUT && $past(CE_IN) |->
    TIMER_COUNT_OUT == {$past(EXT_REG_IN), $past(ACCUM_IN)}) else $error("timer value wrong");
  AST_ACC_ZF: assert property (ACC_WR_OUT |->
    ZF_WR_OUT && ZF_DATA_OUT == (ACC_DATA_OUT == 4'h0)) else $error("zero flag wrong");
  // Any enabled step either counts on or stays in the page
  AST_PC_PAGE: assert property ($past(CE_IN) && $past(RST_N_IN) |->
    PC_OUT == $past(PC_OUT) + 1'b1 || PC_OUT[PC_W-1:8] == $past(PC_OUT[PC_W-1:8]))
    else $error("page bits changed");
  AST_CTL_SRC: assert property ($changed(CONTROL_BITS_OUT) |->
    $past(ROM_DATA_IN[7:4]) == 4'hc) else $error("control changed without mask byte");
  AST_CTL_OR: assert property ($past(ROM_DATA_IN, 2) == 8'h28 && $past(CE_IN) &&
    $past(ROM_DATA_IN[7:4]) == 4'hc |-> CONTROL_BITS_OUT ==
    ($past(CONTROL_BITS_OUT) | $past(ROM_DATA_IN[3:0]))) else $error("control set wrong");
  AST_CTL_AND: assert property ($past(ROM_DATA_IN, 2) == 8'h29 && $past(CE_IN) &&
    $past(ROM_DATA_IN[7:4]) == 4'hc |-> CONTROL_BITS_OUT ==
    ($past(CONTROL_BITS_OUT) & ~$past(ROM_DATA_IN[3:0]))) else $error("control clear wrong");
  AST_PORT_OUT: assert property ($past(ROM_DATA_IN) == 8'h61 && $past(CE_IN) |->
    4'(PORT_PINS_OUT >> {$past(DATA_POINTER_LOW_IN), 2'h0}) == $past(ACCUM_IN))
    else $error("port latch wrong");
endmodule : branch_io_ctl_monitor

//--- sim/port_pins_model.sv
module port_pins_model (
  input wire logic clk_in,
  input wire logic [63:0] latch_in,
  output logic [63:0] pins_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pins follow the output latches one cycle late, like a slow board load
  always_ff @(posedge clk_in) begin
    pins_out <= latch_in;
  end
endmodule : port_pins_model

//--- sim/tb_branch_io_ctl_instr_exec.sv
module tb_branch_io_ctl_instr_exec;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK_IN = 1'h0, RST_N_IN = 1'h0, CE_IN = 1'h1, CARRY_FLAG_IN = 1'h0;
  logic ZERO_FLAG_IN = 1'h0, ACC_WR_OUT, ZF_WR_OUT, ZF_DATA_OUT, EXT_WR_OUT;
  logic TIMER_LOAD_OUT, TIMER_OVF_CLR_OUT;
  logic [15:0] GEN_FLAGS_IN = 16'h0;
  logic [3:0] ACCUM_IN = 4'h0, EXT_REG_IN = 4'h0, DATA_POINTER_LOW_IN = 4'h0;
  logic [3:0] ACC_DATA_OUT, EXT_DATA_OUT, CONTROL_BITS_OUT;
  logic [63:0] PORT_PINS_IN, PORT_PINS_OUT;
  logic [10:0] PC_OUT, p;
  logic [7:0] ROM_DATA_IN, TIMER_COUNT_OUT;
  logic [7:0] rom [0:2047];
  int fail_count = 0, checks_done = 0;
  // Branch cases: first nibble, test nibble, {0, carry, zero, taken}
  logic [11:0] brt [8] = '{12'h3f1, 12'h3f4, 12'h7f5, 12'h7f0,
    12'h7e3, 12'h7e4, 12'h3e1, 12'h3e2};
  // Combinational program memory, as the core expects
  assign ROM_DATA_IN = rom[PC_OUT];
  always #5 CLOCK_IN = ~CLOCK_IN;
  branch_io_ctl_instr_exec branch_io_ctl_instr_exec_inst (.CLOCK_IN(CLOCK_IN),
    .RST_N_IN(RST_N_IN), .CE_IN(CE_IN), .ROM_DATA_IN(ROM_DATA_IN),
    .CARRY_FLAG_IN(CARRY_FLAG_IN), .ZERO_FLAG_IN(ZERO_FLAG_IN), .GEN_FLAGS_IN(GEN_FLAGS_IN),
    .ACCUM_IN(ACCUM_IN), .EXT_REG_IN(EXT_REG_IN), .DATA_POINTER_LOW_IN(DATA_POINTER_LOW_IN),
    .PORT_PINS_IN(PORT_PINS_IN), .PC_OUT(PC_OUT), .PORT_PINS_OUT(PORT_PINS_OUT),
    .ACC_WR_OUT(ACC_WR_OUT), .ACC_DATA_OUT(ACC_DATA_OUT), .ZF_WR_OUT(ZF_WR_OUT),
    .ZF_DATA_OUT(ZF_DATA_OUT), .EXT_WR_OUT(EXT_WR_OUT), .EXT_DATA_OUT(EXT_DATA_OUT),
    .CONTROL_BITS_OUT(CONTROL_BITS_OUT), .TIMER_LOAD_OUT(TIMER_LOAD_OUT),
    .TIMER_COUNT_OUT(TIMER_COUNT_OUT), .TIMER_OVF_CLR_OUT(TIMER_OVF_CLR_OUT));
  port_pins_model port_pins_model_inst (.clk_in(CLOCK_IN), .latch_in(PORT_PINS_OUT),
    .pins_out(PORT_PINS_IN));
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Places an instruction at the current PC, then lets it run
  task automatic ex(input logic [7:0] b1, input logic [7:0] b2, input int n);
    rom[PC_OUT] = b1;
    rom[PC_OUT + 11'h1] = b2;
    repeat (n) @(negedge CLOCK_IN);
  endtask : ex
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  // Whole run is under a thousand cycles
  initial begin
    #50us;
    fail_count++;
    end_of_test();
  end
  initial begin
    for (int i = 0; i < 2048; i++) begin
      rom[i] = 8'h00;
    end
    repeat (20) @(negedge CLOCK_IN);
    RST_N_IN = 1'h1;
    // Foreign opcodes take one cycle each, so page one is reached
    repeat (256) @(negedge CLOCK_IN);
    chk("pc", 16'(PC_OUT), 16'h100);
    CE_IN = 1'h0;
    repeat (3) @(negedge CLOCK_IN);
    chk("pc", 16'(PC_OUT), 16'h100);
    CE_IN = 1'h1;
    for (int i = 0; i < 8; i++) begin
      {CARRY_FLAG_IN, ZERO_FLAG_IN} = brt[i][2:1];
      p = PC_OUT;
      ex({brt[i][11:8], 4'ha}, {brt[i][7:4], 4'h5}, 2);
      chk("pc", 16'(PC_OUT), brt[i][0] ? {p[10:8], 8'ha5} : p + 11'h2);
    end
    for (int n = 0; n < 16; n++) begin
      GEN_FLAGS_IN = 16'h1 << n;
      p = PC_OUT;
      ex(8'hda, {4'(n), 4'h5}, 2);
      chk("pc", 16'(PC_OUT), {p[10:8], 8'ha5});
      ex(8'h9a, {4'(n), 4'h5}, 2);
      chk("pc", 16'(PC_OUT), {p[10:8], 8'ha7});
      GEN_FLAGS_IN = ~GEN_FLAGS_IN;
      ex(8'h9b, {4'(n), 4'h5}, 2);
      chk("pc", 16'(PC_OUT), {p[10:8], 8'hb5});
    end
    for (int k = 0; k < 16; k++) begin
      {DATA_POINTER_LOW_IN, ACCUM_IN} = {4'(k), 4'(k)};
      ex(8'h61, 8'h00, 1);
      chk("latch", 16'(PORT_PINS_OUT[4*k +: 4]), 16'(k));
    end
    // Pins reach the reader through a three-stage synchroniser
    repeat (5) ex(8'h00, 8'h00, 1);
    for (int k = 0; k < 16; k++) begin
      DATA_POINTER_LOW_IN = 4'(k);
      ex(8'h0c, 8'h00, 1);
      chk("acc", {ACC_WR_OUT, ZF_WR_OUT, ZF_DATA_OUT, ACC_DATA_OUT}, {2'h3, k == 0, 4'(k)});
    end
    DATA_POINTER_LOW_IN = 4'h3;
    ex(8'h06, 8'h00, 2);
    chk("bit", 16'(PORT_PINS_OUT[15:12]), 16'h7);
    ex(8'h24, 8'h00, 2);
    chk("bit", {ZF_WR_OUT, EXT_WR_OUT, ZF_DATA_OUT, EXT_DATA_OUT, PORT_PINS_OUT[15:12]}, 16'h676);
    DATA_POINTER_LOW_IN = 4'h0;
    ex(8'h25, 8'h00, 2);
    chk("bit", {ZF_WR_OUT, EXT_WR_OUT, ZF_DATA_OUT, EXT_DATA_OUT, PORT_PINS_OUT[3:0]}, 16'h700);
    ex(8'h28, 8'hb3, 2);
    chk("ctl", 16'(CONTROL_BITS_OUT), 16'h0);
    ex(8'h28, 8'hca, 2);
    chk("ctl", 16'(CONTROL_BITS_OUT), 16'ha);
    ex(8'h28, 8'hc5, 2);
    chk("ctl", 16'(CONTROL_BITS_OUT), 16'hf);
    ex(8'h29, 8'hc6, 2);
    chk("ctl", {ZF_DATA_OUT, CONTROL_BITS_OUT}, 16'h09);
    ex(8'h29, 8'hcf, 2);
    chk("ctl", {ZF_DATA_OUT, CONTROL_BITS_OUT}, 16'h10);
    {EXT_REG_IN, ACCUM_IN} = 8'h69;
    ex(8'hf9, 8'h00, 1);
    chk("tmr", {TIMER_LOAD_OUT, TIMER_OVF_CLR_OUT, TIMER_COUNT_OUT}, 16'h369);
    end_of_test();
  end
endmodule : tb_branch_io_ctl_instr_exec
bind branch_io_ctl_instr_exec branch_io_ctl_monitor #(.PC_W(PC_W), .NUM_PORTS(NUM_PORTS))
  branch_io_ctl_monitor_inst (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN), .CE_IN(CE_IN),
  .ROM_DATA_IN(ROM_DATA_IN), .ACCUM_IN(ACCUM_IN), .EXT_REG_IN(EXT_REG_IN),
  .DATA_POINTER_LOW_IN(DATA_POINTER_LOW_IN), .PC_OUT(PC_OUT), .PORT_PINS_OUT(PORT_PINS_OUT),
  .ACC_WR_OUT(ACC_WR_OUT), .ACC_DATA_OUT(ACC_DATA_OUT), .ZF_WR_OUT(ZF_WR_OUT),
  .ZF_DATA_OUT(ZF_DATA_OUT), .CONTROL_BITS_OUT(CONTROL_BITS_OUT),
  .TIMER_LOAD_OUT(TIMER_LOAD_OUT), .TIMER_COUNT_OUT(TIMER_COUNT_OUT),
  .TIMER_OVF_CLR_OUT(TIMER_OVF_CLR_OUT));
